// ### rtl/asfp_port.v
// Serial frame port of a multichannel SAR converter, device side
`include "asfp_regs.vh"
`default_nettype none
module asfp_port #(
   parameter RES_MODE   = 2'h0,
   parameter SCAN_COUNT = `ASFP_SCAN_CYCLES
) (
   input  wire        ref_clk_i,
   input  wire        nrst_i,
   input  wire        cs_n_i,
   input  wire        sclk_i,
   input  wire        sdi_i,
   input  wire        conversion_start_n_i,
   input  wire [11:0] adc_result_i,
   input  wire [3:0]  adc_channel_i,
   output reg         sdo_o,
   output wire        sdo_oe_o,
   output reg         eoc_n_o,
   output reg         sample_o,
   output reg  [15:0] ctrl_word_o,
   output reg         ctrl_valid_o
);
   wire cs_n_s;
   wire sclk_s;
   wire sdi_s;
   wire cnv_n_s;

   asfp_sync #(.RESET_VAL(1'b1)) u_sync_cs (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .pin_i     (cs_n_i),
      .sync_o    (cs_n_s)
   );
   asfp_sync #(.RESET_VAL(1'b1)) u_sync_sclk (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .pin_i     (sclk_i),
      .sync_o    (sclk_s)
   );
   asfp_sync #(.RESET_VAL(1'b0)) u_sync_sdi (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .pin_i     (sdi_i),
      .sync_o    (sdi_s)
   );
   asfp_sync #(.RESET_VAL(1'b1)) u_sync_cnv (
      .ref_clk_i (ref_clk_i),
      .nrst_i    (nrst_i),
      .pin_i     (conversion_start_n_i),
      .sync_o    (cnv_n_s)
   );

   reg                      cs_n_q;
   reg                      sclk_q;
   reg                      cnv_n_q;
   reg [`ASFP_CNT_W-1:0]    in_cnt_q;
   reg [`ASFP_CNT_W-1:0]    out_cnt_q;
   reg [15:0]               in_sh_q;
   reg [15:0]               out_sh_q;
   reg                      tag_en_q;
   reg                      int_clk_q;
   reg                      scanning_q;
   reg [`ASFP_SCAN_CNT_W-1:0] scan_cnt_q;
   wire [11:0]              res_mask;
   reg [15:0]               word_d;
   reg                      first_fall_q;

   wire cs_fall  = cs_n_q & ~cs_n_s;
   wire cs_rise  = ~cs_n_q & cs_n_s;
   // Edges only count inside a frame, so stray clocks are ignored
   wire active   = ~cs_n_s & ~cs_n_q;
   wire sclk_up  = active & ~sclk_q & sclk_s;
   wire sclk_dn  = active & sclk_q & ~sclk_s;
   wire cnv_fall = cnv_n_q & ~cnv_n_s;
   wire cnv_rise = ~cnv_n_q & cnv_n_s;

   // Output released while select is high
   assign sdo_oe_o = ~cs_n_s;

   // Mask depends on a parameter only, so no process would ever wake up
   assign res_mask = (RES_MODE == `ASFP_RES_MODE_10) ? `ASFP_MASK_10 :
                     (RES_MODE == `ASFP_RES_MODE_8)  ? `ASFP_MASK_8  :
                     `ASFP_MASK_12;

   always @*
   begin
      // Untagged layout is only legal in external clock mode
      if (tag_en_q || int_clk_q)
         word_d = {adc_channel_i, adc_result_i & res_mask};
      else
         word_d = {1'b0, adc_result_i & res_mask,
                   `ASFP_TRAIL_ZERO};
   end

   always @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cs_n_q       <= 1'b1;
         sclk_q       <= 1'b1;
         cnv_n_q      <= 1'b1;
         in_cnt_q     <= `ASFP_CNT_ZERO;
         out_cnt_q    <= `ASFP_CNT_ZERO;
         in_sh_q      <= `ASFP_WORD_ZERO;
         out_sh_q     <= `ASFP_WORD_ZERO;
         sdo_o        <= 1'b0;
         sample_o     <= 1'b0;
         ctrl_word_o  <= `ASFP_WORD_ZERO;
         ctrl_valid_o <= 1'b0;
         tag_en_q     <= 1'b1;
         int_clk_q    <= 1'b0;
         first_fall_q <= 1'b0;
      end
      else
      begin
         cs_n_q       <= cs_n_s;
         sclk_q       <= sclk_s;
         cnv_n_q      <= cnv_n_s;
         sample_o     <= cs_fall;
         ctrl_valid_o <= 1'b0;
         if (cs_fall)
         begin
            in_cnt_q     <= `ASFP_CNT_ZERO;
            out_cnt_q    <= `ASFP_CNT_ZERO;
            // Format latched here; later config writes apply next frame
            out_sh_q     <= word_d;
            sdo_o        <= word_d[`ASFP_WORD_BITS-1];
            first_fall_q <= 1'b1;
         end
         else
         begin
            if (sclk_up && in_cnt_q != `ASFP_CNT_FULL)
            begin
               in_sh_q  <= {in_sh_q[14:0], sdi_s};
               in_cnt_q <= in_cnt_q + 1'b1;
               if (in_cnt_q == `ASFP_CNT_FULL - 1'b1)
               begin
                  ctrl_word_o  <= {in_sh_q[14:0], sdi_s};
                  ctrl_valid_o <= 1'b1;
                  tag_en_q     <= in_sh_q[`ASFP_CFG_TAG_BIT-1];
                  int_clk_q    <= in_sh_q[`ASFP_CFG_INTCLK_BIT-1];
               end
            end
            // First falling edge keeps the MSB, later ones advance
            if (sclk_dn && out_cnt_q != `ASFP_CNT_FULL)
            begin
               out_cnt_q <= out_cnt_q + 1'b1;
               if (first_fall_q)
                  first_fall_q <= 1'b0;
               else
               begin
                  out_sh_q <= {out_sh_q[14:0], 1'b0};
                  sdo_o    <= out_sh_q[14];
               end
            end
         end
      end
   end

   // Internal-clock scan timer and end-of-conversion flag
   always @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scanning_q <= 1'b0;
         scan_cnt_q <= {`ASFP_SCAN_CNT_W{1'b0}};
         eoc_n_o    <= 1'b1;
      end
      else
      begin
         if (cs_fall || cnv_fall)
            eoc_n_o <= 1'b1;
         if (cnv_rise && cs_n_s && int_clk_q)
         begin
            scanning_q <= 1'b1;
            scan_cnt_q <= SCAN_COUNT[`ASFP_SCAN_CNT_W-1:0];
         end
         else if (scanning_q)
         begin
            if (scan_cnt_q == {`ASFP_SCAN_CNT_W{1'b0}})
            begin
               scanning_q <= 1'b0;
               eoc_n_o    <= 1'b0;
            end
            else
               scan_cnt_q <= scan_cnt_q - 1'b1;
         end
      end
   end
endmodule // asfp_port
`default_nettype wire

// ### rtl/asfp_regs.vh
// Constants for the ADC serial frame port
// Notes on behaviour
// - Port reacts to serial clock and data only while chip select is low.
// - Serial output released while select is high; driven only while low.
// - Each of the first 16 serial input bits is captured on a serial clock rising edge; later bits are ignored.
// - Serial output bit changes on serial clock falling edges 2 to 16 of a frame; later falls leave it.
// - Internal clock mode only: end-of-conversion low marks valid data.
// - Active-low start input requests an internally timed conversion.
// - Start pulse, select high; scan, then end flag low until a fall.
// - Serial clock idles high; host uses polarity and phase both one.
// - Select falling edge samples analog inputs and begins a new frame.
// - Serial input bits are written into the control registers.
// - Tag on: word is 4-bit channel then 12-bit result, MSB first.
// - Tag off, external mode only: one zero, 12-bit result, three zeros.
// - 10-bit variant zeroes two LSBs; 8-bit variant zeroes four LSBs.
`ifndef ASFP_REGS_VH
`define ASFP_REGS_VH
`define ASFP_WORD_BITS      16
`define ASFP_RES_BITS       12
`define ASFP_CHAN_BITS      4
`define ASFP_CNT_W          5
`define ASFP_CNT_ZERO       5'h00
`define ASFP_CNT_FULL       5'h10
`define ASFP_WORD_ZERO      16'h0000
`define ASFP_RES_ZERO       12'h000
`define ASFP_CHAN_ZERO      4'h0
`define ASFP_TRAIL_ZERO     3'h0
`define ASFP_CFG_TAG_BIT    15
`define ASFP_CFG_INTCLK_BIT 14
`define ASFP_RES_MODE_12    2'h0
`define ASFP_RES_MODE_10    2'h1
`define ASFP_RES_MODE_8     2'h2
`define ASFP_MASK_12        12'hfff
`define ASFP_MASK_10        12'hffc
`define ASFP_MASK_8         12'hff0
`define ASFP_SCAN_TIME_NS   6200
`define ASFP_CLK_PERIOD_NS  4
`define ASFP_SCAN_CYCLES    (`ASFP_SCAN_TIME_NS / `ASFP_CLK_PERIOD_NS)
`define ASFP_SCAN_CNT_W     12
`endif

// ### rtl/asfp_sync.v
// Two-flop synchroniser for pins from outside the clock domain
`default_nettype none
module asfp_sync #(
   parameter RESET_VAL = 1'b1
) (
   input  wire ref_clk_i,
   input  wire nrst_i,
   input  wire pin_i,
   output reg  sync_o
);
   reg meta_q;

   always @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_q <= RESET_VAL;
         sync_o <= RESET_VAL;
      end
      else
      begin
         meta_q <= pin_i;
         sync_o <= meta_q;
      end
   end
endmodule // asfp_sync
`default_nettype wire

// ### testbench/asfp_port_props.sv
// Checker for the serial frame port
`default_nettype none
module asfp_port_props #(
   parameter int SCAN_COUNT = 20
) (
   input wire logic        ref_clk_i,
   input wire logic        nrst_i,
   input wire logic        cs_n_i,
   input wire logic        sclk_i,
   input wire logic        conversion_start_n_i,
   input wire logic        sdo_o,
   input wire logic        sdo_oe_o,
   input wire logic        eoc_n_o,
   input wire logic        sample_o,
   input wire logic [15:0] ctrl_word_o,
   input wire logic        ctrl_valid_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slack covers the two sync flops and the edge finder
   localparam int SC_HI = SCAN_COUNT + 8;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_oe_off_idle: assert property (cs_n_i[*4] |-> !sdo_oe_o)
      else $error("output driven while deselected");
   a_oe_on_frame: assert property ((!cs_n_i)[*4] |-> sdo_oe_o)
      else $error("output not driven in frame");
   a_sample_on_fall: assert property (
      $fell(cs_n_i) |-> ##[2:6] sample_o)
      else $error("no sample pulse after select fall");
   a_idle_quiet: assert property (
      cs_n_i[*8] |-> !sample_o && !ctrl_valid_o)
      else $error("activity while deselected");
   a_word_update: assert property (
      $changed(ctrl_word_o) |-> ctrl_valid_o)
      else $error("command word changed without pulse");
   a_sdo_hold: assert property (
      !sclk_i ##1 (sclk_i && !cs_n_i)[*4] |=> $stable(sdo_o))
      else $error("output bit moved with clock high");
   a_eoc_release: assert property (
      $fell(cs_n_i) |-> ##[1:6] eoc_n_o)
      else $error("end flag not released by select");
   a_eoc_timing: assert property (
      $rose(conversion_start_n_i) && cs_n_i && ctrl_word_o[14]
      |-> ##[1:SC_HI] !eoc_n_o)
      else $error("end flag late after start");
   // External clock mode has no end flag at all
   a_eoc_int_only: assert property (
      $fell(eoc_n_o) |-> ctrl_word_o[14])
      else $error("end flag dropped in external clock mode");
   c_frame: cover property (sample_o);
   c_cmd: cover property (ctrl_valid_o);
   c_eoc: cover property ($fell(eoc_n_o));
endmodule // asfp_port_props
bind asfp_port asfp_port_props #(
   .SCAN_COUNT (SCAN_COUNT)
) asfp_port_props_inst (
   .ref_clk_i            (ref_clk_i),
   .nrst_i               (nrst_i),
   .cs_n_i               (cs_n_i),
   .sclk_i               (sclk_i),
   .conversion_start_n_i (conversion_start_n_i),
   .sdo_o                (sdo_o),
   .sdo_oe_o             (sdo_oe_o),
   .eoc_n_o              (eoc_n_o),
   .sample_o             (sample_o),
   .ctrl_word_o          (ctrl_word_o),
   .ctrl_valid_o         (ctrl_valid_o)
);
`default_nettype wire

// ### testbench/asfp_host.sv
// Host model: serial master that frames commands and reads result words
`default_nettype none
module asfp_host (
   input  wire logic ref_clk_i,
   input  wire logic sdo_i,
   output var  logic cs_n_o,
   output var  logic sclk_o,
   output var  logic sdi_o,
   output var  logic start_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b1;
      sdi_o = 1'b0;
      start_n_o = 1'b1;
   end
   task automatic frame(input logic [15:0] cmd, input int n,
                        output logic [15:0] rx);
      repeat (8) @(posedge ref_clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
      for (int k = 1; k <= n; k++)
      begin
         sclk_o <= 1'b0;
         sdi_o <= (k <= 16) ? cmd[16-k] : ~sdi_o;
         repeat (4) @(posedge ref_clk_i);
         sclk_o <= 1'b1;
         repeat (4) @(posedge ref_clk_i);
         // Read late in the high phase, the bit stands until the next fall
         if (k <= 16) rx[16-k] = sdo_i;
      end
      repeat (8) @(posedge ref_clk_i);
      cs_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
   endtask
   task automatic pulse_start();
      start_n_o <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      start_n_o <= 1'b1;
   endtask
endmodule // asfp_host
`default_nettype wire

// ### testbench/tb_asfp_port.sv
// Self-checking bench for the serial frame port
`default_nettype none
module tb_asfp_port;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SCAN = 20;
   logic ref_clk_i, nrst_i, cs_n_i, sclk_i, sdi_i, conversion_start_n_i;
   logic sdo_o, sdo_oe_o, eoc_n_o, sample_o, ctrl_valid_o;
   logic [11:0] adc_result_i;
   logic [3:0]  adc_channel_i;
   logic [15:0] ctrl_word_o, rx, lfsr, last;
   int          error_cnt, checks_done;
   // Released line shows the inverse, so a stale bit cannot pass
   wire logic   sdo_line = sdo_oe_o ? sdo_o : ~sdo_o;
   asfp_port #(
      .RES_MODE   (2'h1),
      .SCAN_COUNT (SCAN)
   ) asfp_port_inst (
      .ref_clk_i            (ref_clk_i),
      .nrst_i               (nrst_i),
      .cs_n_i               (cs_n_i),
      .sclk_i               (sclk_i),
      .sdi_i                (sdi_i),
      .conversion_start_n_i (conversion_start_n_i),
      .adc_result_i         (adc_result_i),
      .adc_channel_i        (adc_channel_i),
      .sdo_o                (sdo_o),
      .sdo_oe_o             (sdo_oe_o),
      .eoc_n_o              (eoc_n_o),
      .sample_o             (sample_o),
      .ctrl_word_o          (ctrl_word_o),
      .ctrl_valid_o         (ctrl_valid_o)
   );
   asfp_host asfp_host_inst (.ref_clk_i(ref_clk_i), .sdo_i(sdo_line),
      .cs_n_o(cs_n_i), .sclk_o(sclk_i), .sdi_o(sdi_i),
      .start_n_o(conversion_start_n_i));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #2 ref_clk_i = ~ref_clk_i;
   end
   function automatic logic [15:0] nxt(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [15:0] exp_word(input logic [15:0] c);
      // 10-bit build: two low result bits read as zero
      if (c[15] | c[14])
         return {adc_channel_i, adc_result_i & 12'hffc};
      return {1'b0, adc_result_i & 12'hffc, 3'h0};
   endfunction
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic run(input logic [15:0] c, input int n);
      logic [15:0] e;
      // Inputs set at the end of the last run have settled only by now
      asfp_host_inst.frame(c, n, rx);
      e = exp_word(last);
      if (n >= 16) check(rx, e);
      if (n >= 16) last = c;
      check(ctrl_word_o, last);
      adc_result_i <= lfsr[11:0];
      adc_channel_i <= lfsr[15:12];
      lfsr = nxt(lfsr);
   endtask
   initial
   begin
      nrst_i = 1'b0;
      adc_result_i = 12'h5a3;
      adc_channel_i = 4'h9;
      lfsr = 16'h0019;
      last = 16'h8000;
      error_cnt = 0;
      checks_done = 0;
      repeat (4) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      check({15'h0, sdo_oe_o}, 16'h0000);
      check({13'h0, eoc_n_o, sample_o, ctrl_valid_o}, 16'h0004);
      run(16'h0000, 16);
      run(16'h0000, 16);
      run(16'h8000, 5);
      run(16'hffff, 18);
      run(16'h4000, 16);
      asfp_host_inst.pulse_start();
      for (int i = 0; i < SCAN + 40 && eoc_n_o !== 1'b0; i++)
         @(posedge ref_clk_i);
      check({15'h0, eoc_n_o}, 16'h0000);
      run(16'h0000, 16);
      check({15'h0, eoc_n_o}, 16'h0001);
      for (int i = 0; i < 12; i++) run(lfsr, 16 + lfsr[1:0]);
      results();
   end
endmodule // tb_asfp_port
`default_nettype wire
